/* File: logic/rsu_pkg.sv */
// Package: constants and types of the register shift unit
package rsu_pkg;

   // ==========================================================
   // Instruction word fields
   localparam int unsigned REG_W = 16;
   localparam int unsigned CNT_LSB = 0;
   localparam int unsigned CNT_W = 6;
   localparam int unsigned SEL_LSB = 7;
   localparam int unsigned TYPE_LSB = 9;

   // ==========================================================
   // Shift type encodings (instruction bits 10:9)
   localparam logic [1:0] TYPE_ARITH = 2'h0;
   localparam logic [1:0] TYPE_ROTATE = 2'h1;
   localparam logic [1:0] TYPE_ZERO_FILL = 2'h2;
   localparam logic [1:0] TYPE_LINK_FILL = 2'h3;

   // ==========================================================
   // Operand selection encodings (instruction bits 8:7)
   localparam logic [1:0] SEL_EXPONENT = 2'h0;
   localparam logic [1:0] SEL_LOW_MANT = 2'h1;
   localparam logic [1:0] SEL_ACC = 2'h2;
   localparam logic [1:0] SEL_JOINED = 2'h3;

   // ==========================================================
   // Timing
   localparam int unsigned CLK_PERIOD_PS = 5000;
   localparam int unsigned MEM_CYCLE_NS = 1000;
   localparam int unsigned STEP_SINGLE_NS = 400;
   localparam int unsigned STEP_DOUBLE_NS = 800;
   localparam int unsigned MEM_CYCLE_CYC =
      (MEM_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned STEP_SINGLE_CYC =
      (STEP_SINGLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned STEP_DOUBLE_CYC =
      (STEP_DOUBLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned TIMER_W = 10;

   // ==========================================================
   // Reset values
   localparam logic LINK_RESET = 1'b0;

   // ==========================================================
   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_MEMC,
      ST_SHIFT,
      ST_DONE
   } rsu_state_e;

endpackage : rsu_pkg

/* File: logic/rsu_step.sv */
// One-position shifter used by the register shift unit
module rsu_step
   import rsu_pkg::*;
(
   // Operand
   input wire logic [2*REG_W-1:0] value_i,
   input wire logic double_i,
   // Control
   input wire logic right_i,
   input wire logic [1:0] type_i,
   input wire logic link_i,
   // Result
   output logic [2*REG_W-1:0] value_o,
   output logic out_bit_o
);

   logic msb;
   logic lsb;
   logic fill;

   always_comb begin
      msb = double_i ? value_i[2*REG_W-1] : value_i[REG_W-1];
      lsb = value_i[0];
      out_bit_o = right_i ? lsb : msb;
      case (type_i)
         TYPE_ARITH: fill = right_i ? msb : 1'b0;
         TYPE_ROTATE: fill = right_i ? lsb : msb;
         TYPE_ZERO_FILL: fill = 1'b0;
         default: fill = link_i;
      endcase
      if (double_i) begin
         // Accumulator bit 0 feeds low mantissa bit 15 and back
         if (right_i) begin
            value_o = {fill, value_i[2*REG_W-1:1]};
         end else begin
            value_o = {value_i[2*REG_W-2:0], fill};
         end
      end else if (right_i) begin
         value_o = {{REG_W{1'b0}}, fill, value_i[REG_W-1:1]};
      end else begin
         value_o = {{REG_W{1'b0}}, value_i[REG_W-2:0], fill};
      end
   end

endmodule : rsu_step

/* File: logic/rsu_shift_unit.sv */
// Register shift unit: sequenced shifter for exponent, mantissa and accumulator
// How it works
// - Shift count is the signed low six instruction bits; negative means right.
// - At most 31 left or 32 right positions per instruction.
// - Time is one memory cycle plus 0.4 us (single) or 0.8 us (double) per place.
// - Bits 10:9 pick arithmetic, rotate, zero fill or link fill shifting.
// - Arithmetic right copies bit 15; arithmetic left feeds zeros.
// - Rotate closes the loop; double rotate joins low mantissa bit 0 to acc bit 15.
// - Link fill uses the link flop and captures the last bit shifted out.
// - Bits 8:7 pick exponent, low mantissa, accumulator or joined pair.
// - Joined shift links acc bit 0 to low mantissa bit 15; acc is high half.
// - Every register is 16 bits with bit 15 as sign.
module rsu_shift_unit
   import rsu_pkg::*;
#(
   parameter int unsigned MEM_CYCLES = MEM_CYCLE_CYC,
   parameter int unsigned STEP_SINGLE = STEP_SINGLE_CYC,
   parameter int unsigned STEP_DOUBLE = STEP_DOUBLE_CYC
)
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Instruction from the sequencer
   input wire logic start_i,
   input wire logic [REG_W-1:0] instr_i,
   // Register contents at start
   input wire logic [REG_W-1:0] exponent_i,
   input wire logic [REG_W-1:0] low_mant_i,
   input wire logic [REG_W-1:0] acc_i,
   // Status to the sequencer
   output logic busy_o,
   output logic done_o,
   output logic link_o,
   // Results and write strobes to the register block
   output logic [REG_W-1:0] exponent_o,
   output logic [REG_W-1:0] low_mant_o,
   output logic [REG_W-1:0] acc_o,
   output logic exponent_we_o,
   output logic low_mant_we_o,
   output logic acc_we_o
);

   // ==========================================================
   // Decode helpers
   function automatic logic [CNT_W-1:0] count_mag(input logic [CNT_W-1:0] n);
      // Two's complement magnitude; 6'h20 gives 32 right places
      count_mag = n[CNT_W-1] ? CNT_W'(~n + 1'b1) : n;
   endfunction : count_mag

   function automatic logic [2*REG_W-1:0] pick_operand(
      input logic [1:0] sel,
      input logic [REG_W-1:0] e,
      input logic [REG_W-1:0] l,
      input logic [REG_W-1:0] a
   );
      case (sel)
         SEL_EXPONENT: pick_operand = {{REG_W{1'b0}}, e};
         SEL_LOW_MANT: pick_operand = {{REG_W{1'b0}}, l};
         SEL_ACC: pick_operand = {{REG_W{1'b0}}, a};
         default: pick_operand = {a, l};
      endcase
   endfunction : pick_operand

   // ==========================================================
   // State
   rsu_state_e state_q;
   logic [2*REG_W-1:0] work_q;
   logic [1:0] type_q;
   logic [1:0] sel_q;
   logic right_q;
   logic [CNT_W-1:0] remain_q;
   logic [TIMER_W-1:0] timer_q;
   logic link_q;
   logic last_bit_q;
   logic shifted_q;

   logic [2*REG_W-1:0] step_value;
   logic step_out;
   logic double_op;
   logic [TIMER_W-1:0] step_len;
   logic [CNT_W-1:0] req_count;

   assign double_op = (sel_q == SEL_JOINED);
   assign req_count = instr_i[CNT_LSB +: CNT_W];
   // Double shifts take twice the time per position
   assign step_len = double_op ? TIMER_W'(STEP_DOUBLE - 1) : TIMER_W'(STEP_SINGLE - 1);

   // ==========================================================
   // One-position shifter
   rsu_step u_step (
      .value_i(work_q),
      .double_i(double_op),
      .right_i(right_q),
      .type_i(type_q),
      .link_i(link_q),
      .value_o(step_value),
      .out_bit_o(step_out)
   );

   // ==========================================================
   // Sequencer
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= ST_IDLE;
         timer_q <= '0;
         remain_q <= '0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (start_i) begin
                  state_q <= ST_MEMC;
                  timer_q <= TIMER_W'(MEM_CYCLES - 1);
                  remain_q <= count_mag(req_count);
               end
            end
            ST_MEMC: begin
               if (timer_q != '0) begin
                  timer_q <= timer_q - 1'b1;
               end else if (remain_q == '0) begin
                  state_q <= ST_DONE;
               end else begin
                  state_q <= ST_SHIFT;
                  timer_q <= step_len;
               end
            end
            ST_SHIFT: begin
               if (timer_q != '0) begin
                  timer_q <= timer_q - 1'b1;
               end else if (remain_q == 6'h01) begin
                  remain_q <= '0;
                  state_q <= ST_DONE;
               end else begin
                  remain_q <= remain_q - 1'b1;
                  timer_q <= step_len;
               end
            end
            ST_DONE: begin
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Operand capture and shifting
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         work_q <= '0;
         type_q <= TYPE_ARITH;
         sel_q <= SEL_EXPONENT;
         right_q <= 1'b0;
         last_bit_q <= 1'b0;
         shifted_q <= 1'b0;
      end else if (state_q == ST_IDLE && start_i) begin
         // Only the three shiftable registers are offered as operands
         work_q <= pick_operand(instr_i[SEL_LSB +: 2], exponent_i, low_mant_i, acc_i);
         type_q <= instr_i[TYPE_LSB +: 2];
         sel_q <= instr_i[SEL_LSB +: 2];
         right_q <= req_count[CNT_W-1];
         shifted_q <= 1'b0;
      end else if (state_q == ST_SHIFT && timer_q == '0) begin
         // The shift happens at the end of each step period
         work_q <= step_value;
         last_bit_q <= step_out;
         shifted_q <= 1'b1;
      end
   end

   // ==========================================================
   // Link flip-flop
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         link_q <= LINK_RESET;
      end else if (state_q == ST_SHIFT && timer_q == '0 && type_q == TYPE_LINK_FILL) begin
         // Updated per place so the next place sees the bit just vacated
         link_q <= step_out;
      end
   end

   // ==========================================================
   // Results and handshake outputs
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_o <= 1'b0;
         done_o <= 1'b0;
         link_o <= LINK_RESET;
         exponent_o <= '0;
         low_mant_o <= '0;
         acc_o <= '0;
         exponent_we_o <= 1'b0;
         low_mant_we_o <= 1'b0;
         acc_we_o <= 1'b0;
      end else begin
         // Busy rises with the accepted start and falls with done
         busy_o <= (state_q == ST_IDLE) ? start_i : (state_q != ST_DONE);
         done_o <= (state_q == ST_DONE);
         link_o <= link_q;
         exponent_we_o <= 1'b0;
         low_mant_we_o <= 1'b0;
         acc_we_o <= 1'b0;
         if (state_q == ST_DONE) begin
            case (sel_q)
               SEL_EXPONENT: begin
                  exponent_o <= work_q[REG_W-1:0];
                  exponent_we_o <= 1'b1;
               end
               SEL_LOW_MANT: begin
                  low_mant_o <= work_q[REG_W-1:0];
                  low_mant_we_o <= 1'b1;
               end
               SEL_ACC: begin
                  acc_o <= work_q[REG_W-1:0];
                  acc_we_o <= 1'b1;
               end
               default: begin
                  acc_o <= work_q[2*REG_W-1:REG_W];
                  low_mant_o <= work_q[REG_W-1:0];
                  acc_we_o <= 1'b1;
                  low_mant_we_o <= 1'b1;
               end
            endcase
         end
      end
   end

endmodule : rsu_shift_unit

/* File: test/rsu_shift_unit_props.sv */
// Port checker of the register shift unit
module rsu_shift_unit_props
   import rsu_pkg::*;
#(
   parameter int unsigned MEM_CYCLES = 2,
   parameter int unsigned STEP_SINGLE = 2,
   parameter int unsigned STEP_DOUBLE = 3
)
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Request
   input wire logic start_i,
   input wire logic [REG_W-1:0] instr_i,
   // Status and results
   input wire logic busy_o,
   input wire logic done_o,
   input wire logic link_o,
   input wire logic [REG_W-1:0] acc_o,
   input wire logic exponent_we_o,
   input wire logic low_mant_we_o,
   input wire logic acc_we_o
);
   // =====================================
   // Checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   logic go;
   assign go = start_i && !busy_o && !done_o;
   chk_done_pulse: assert property (done_o |=> !done_o)
      else $error("done held");
   chk_busy_run: assert property (go |=> busy_o [*2])
      else $error("busy short");
   chk_zero_time: assert property (go && instr_i[5:0] == 6'h00 |-> ##(MEM_CYCLES + 2) done_o)
      else $error("zero count time");
   chk_single_time: assert property (go && instr_i[5:0] == 6'h3F && instr_i[8:7] != 2'h3
      |-> ##(MEM_CYCLES + STEP_SINGLE + 2) done_o)
      else $error("single time");
   chk_double_time: assert property (go && instr_i[5:0] == 6'h3F && instr_i[8:7] == 2'h3
      |-> ##(MEM_CYCLES + STEP_DOUBLE + 2) done_o)
      else $error("double time");
   chk_we_done: assert property (exponent_we_o || low_mant_we_o || acc_we_o |-> done_o)
      else $error("stray strobe");
   chk_we_kind: assert property (done_o
      |-> $onehot({exponent_we_o, low_mant_we_o, acc_we_o}) || acc_we_o && low_mant_we_o)
      else $error("strobe set");
   chk_link_quiet: assert property ($changed(link_o) |-> $past(busy_o))
      else $error("link moved idle");
   chk_acc_hold: assert property ($changed(acc_o) |-> acc_we_o)
      else $error("acc moved");
endmodule : rsu_shift_unit_props

bind rsu_shift_unit rsu_shift_unit_props #(.MEM_CYCLES(MEM_CYCLES), .STEP_SINGLE(STEP_SINGLE),
   .STEP_DOUBLE(STEP_DOUBLE)) props_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
   .start_i(start_i), .instr_i(instr_i), .busy_o(busy_o), .done_o(done_o), .link_o(link_o),
   .acc_o(acc_o), .exponent_we_o(exponent_we_o), .low_mant_we_o(low_mant_we_o),
   .acc_we_o(acc_we_o));

/* File: test/rsu_reg_model.sv */
// Register block model holding the three shiftable registers
module rsu_reg_model
   import rsu_pkg::*;
#(
   parameter logic [REG_W-1:0] EXP_INIT = 16'h9A53,
   parameter logic [REG_W-1:0] LOW_INIT = 16'hC3A5,
   parameter logic [REG_W-1:0] ACC_INIT = 16'hB1E6
)
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Results and strobes
   input wire logic [REG_W-1:0] exponent_i,
   input wire logic [REG_W-1:0] low_mant_i,
   input wire logic [REG_W-1:0] acc_i,
   input wire logic exponent_we_i,
   input wire logic low_mant_we_i,
   input wire logic acc_we_i,
   // Register contents
   output logic [REG_W-1:0] exponent_o,
   output logic [REG_W-1:0] low_mant_o,
   output logic [REG_W-1:0] acc_o
);
   // =====================================
   // Write-back, only these three reach the shifter
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         exponent_o <= EXP_INIT;
         low_mant_o <= LOW_INIT;
         acc_o <= ACC_INIT;
      end else begin
         if (exponent_we_i) exponent_o <= exponent_i;
         if (low_mant_we_i) low_mant_o <= low_mant_i;
         if (acc_we_i) acc_o <= acc_i;
      end
   end
endmodule : rsu_reg_model

/* File: test/rsu_shift_unit_test.sv */
// Self-checking bench of the register shift unit
module rsu_shift_unit_test
   import rsu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // =====================================
   // Signals
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic start_i = 1'b0;
   logic [REG_W-1:0] instr_i = 16'h0000;
   logic [REG_W-1:0] e_v, l_v, a_v, e_r, l_r, a_r;
   logic busy_o, done_o, link_o, e_we, l_we, a_we;
   int mismatches = 0;
   int check_count = 0;
   int cyc = 0;
   logic [REG_W-1:0] m_e = 16'h9A53;
   logic [REG_W-1:0] m_l = 16'hC3A5;
   logic [REG_W-1:0] m_a = 16'hB1E6;
   logic m_k = 1'b0;
   logic [5:0] cnts [4] = '{6'h00, 6'h3F, 6'h20, 6'h1F};
   initial forever #2.5 clock_i = ~clock_i;
   rsu_shift_unit #(.MEM_CYCLES(2), .STEP_SINGLE(2), .STEP_DOUBLE(3)) rsu_shift_unit_inst (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .start_i(start_i), .instr_i(instr_i),
      .exponent_i(e_v), .low_mant_i(l_v), .acc_i(a_v), .busy_o(busy_o), .done_o(done_o),
      .link_o(link_o), .exponent_o(e_r), .low_mant_o(l_r), .acc_o(a_r),
      .exponent_we_o(e_we), .low_mant_we_o(l_we), .acc_we_o(a_we));
   // Register seeds are the model's defaults and match m_e, m_l and m_a above
   rsu_reg_model rsu_reg_model_inst (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .exponent_i(e_r), .low_mant_i(l_r), .acc_i(a_r),
      .exponent_we_i(e_we), .low_mant_we_i(l_we), .acc_we_i(a_we),
      .exponent_o(e_v), .low_mant_o(l_v), .acc_o(a_v));
   // =====================================
   // Tasks
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // Reference shifter, one place per pass like the hardware
   function automatic logic [32:0] shift(input logic [31:0] v, input logic dbl,
      input logic [1:0] t, input logic [5:0] c, input logic k);
      int w;
      int n;
      logic o;
      logic f;
      w = dbl ? 32 : 16;
      n = $signed(c);
      for (int i = 0; i < (n < 0 ? -n : n); i++) begin
         o = n < 0 ? v[0] : v[w-1];
         f = t == TYPE_ROTATE ? o : t == TYPE_LINK_FILL ? k : t == TYPE_ARITH && n < 0 && v[w-1];
         v = n < 0 ? v >> 1 : v << 1;
         v[n < 0 ? w - 1 : 0] = f;
         if (!dbl) v[31:16] = 16'h0000;
         if (t == TYPE_LINK_FILL) k = o;
      end
      return {k, v};
   endfunction : shift
   task automatic run(input logic [1:0] t, input logic [1:0] s, input logic [5:0] c);
      logic [32:0] r;
      int n;
      int k;
      logic [31:0] g;
      r = shift(s == 2'h3 ? {m_a, m_l} : {16'h0000, s == 2'h0 ? m_e : s == 2'h1 ? m_l : m_a},
         s == 2'h3, t, c, m_k);
      n = $signed(c);
      n = n < 0 ? -n : n;
      @(posedge clock_i);
      instr_i <= {5'h00, t, s, 1'b0, c};
      start_i <= 1'b1;
      @(posedge clock_i);
      start_i <= 1'b0;
      for (k = 1; k < 200; k++) begin
         @(posedge clock_i);
         start_i <= k == 1;
         #1;
         if (k == 1) cmp(busy_o, 1'b1);
         if (done_o === 1'b1) break;
      end
      cmp(k, 3 + n * (s == 2'h3 ? 3 : 2));
      cmp(busy_o, 1'b0);
      cmp({e_we, l_we, a_we}, {s == 2'h0, s[0], s[1]});
      g = s == 2'h3 ? {a_r, l_r} : {16'h0000, s == 2'h0 ? e_r : s == 2'h1 ? l_r : a_r};
      cmp(g, r[31:0]);
      cmp(link_o, r[32]);
      m_k = r[32];
      if (s == 2'h0) m_e = r[15:0];
      if (s == 2'h1) m_l = r[15:0];
      if (s == 2'h2) m_a = r[15:0];
      if (s == 2'h3) {m_a, m_l} = r[31:0];
      $display("test type %0d operand %0d count %h done", t, s, c);
   endtask : run
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test
   // =====================================
   // Sequence, with a ceiling well above the roughly 670 cycles needed
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         $display("ERROR %0t timeout", $time);
         mismatches++;
         end_of_test;
      end
   end
   initial begin
      repeat (10) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      #1;
      cmp({busy_o, done_o, link_o, e_we, l_we, a_we}, 32'h0);
      for (int t = 0; t < 4; t++) begin
         for (int s = 0; s < 4; s++) begin
            run(t[1:0], s[1:0], cnts[(t + s) % 4]);
         end
      end
      end_of_test;
   end
endmodule : rsu_shift_unit_test
